// ==== rtl/ppc_map.vh ====
`ifndef PPC_MAP_VH
`define PPC_MAP_VH
// ==========================================
// Register offsets (word addresses)
`define PPC_OFS_IN_MODE0   4'h0
`define PPC_OFS_IN_MODE1   4'h1
`define PPC_OFS_IN_MODE2   4'h2
`define PPC_OFS_OUT_MODE0  4'h3
`define PPC_OFS_OUT_MODE1  4'h4
`define PPC_OFS_OUT_MODE2  4'h5
`define PPC_OFS_SKIP0      4'h6
`define PPC_OFS_SKIP1      4'h7
`define PPC_OFS_SKIP2      4'h8
`define PPC_OFS_OUT0       4'h9
`define PPC_OFS_OUT1       4'hA
`define PPC_OFS_OUT2       4'hB
`define PPC_OFS_PIN_READ   4'hC
`define PPC_OFS_CTRL       4'hD
`define PPC_OFS_MATCH      4'hE
`define PPC_OFS_IRQ        4'hF
// ==========================================
// Field positions
`define PPC_CTRL_XBAR_BIT  0
`define PPC_CTRL_WPUD_BIT  1
`define PPC_IRQ_STAT_LSB   0
`define PPC_IRQ_MASK_LSB   8
// ==========================================
// Sizes and reset values
`define PPC_NPIN           21
`define PPC_RST_IN_MODE    21'h1FFFFF
`define PPC_RST_ZERO       21'h00000
`define PPC_RST_PAD        21'h1FFFFF
`define PPC_RST_OUT        21'h1FFFFF
`define PPC_NEV            3
`endif

// ==== rtl/ppc_pin_cell.v ====
// ==========================================
// One port pin cell: drivers, pull-up, input receiver
module ppc_pin_cell (
   input  wire in_digital,
   input  wire push_pull,
   input  wire out_val,
   input  wire drv_allow,
   input  wire pu_disable,
   input  wire pad_sync,
   output wire pad_o,
   output wire pad_oe_n,
   output wire pullup_en,
   output wire pin_read
);
   // Drivers: low side when value is 0, high side only in push-pull
   wire drive_low  = drv_allow & in_digital & ~out_val;                 // R2 R3 R6
   wire drive_high = drv_allow & in_digital & push_pull & out_val;      // R2 R3 R5 R6
   assign pad_o    = out_val;
   assign pad_oe_n = ~(drive_low | drive_high);                          // R5
   // Pull-up only on digital, undriven pins, not globally off
   assign pullup_en = in_digital & ~pu_disable & ~drive_low & ~drive_high; // R3 R7 R8
   // Receiver is off in analog mode and reads 0
   assign pin_read = in_digital & pad_sync;                              // R4 R9
endmodule

// ==== rtl/ppc_port.v ====
// Operation
// R1: After reset pins are high impedance with pull-ups on.
// R2: Crossbar disabled keeps both output drivers off on all pins.
// R3: Analog mode turns off pull-up, driver and receiver.
// R4: Analog pins read back 0.
// R5: Push-pull digital pins drive pad to the output value.
// R6: Open-drain pins only drive low; value 1 leaves pad undriven.
// R7: Undriven digital pins are pulled high; pull-up off while driving low.
// R8: Global pull-up disable bit turns off every pull-up.
// R9: Digital pins read the real pad level.
// R10: Skipped pins are reserved and never get crossbar signals.
// R11: Fixed analog functions use pins P0.0 to P0.3.
// R12: Primary UART always lands on P0.4 and P0.5.
// R13: Crossbar signals only go to unskipped pins P0.0 to P2.3.
// R14: Pins P0.0 to P2.4 usable as GPIO, chosen by skip registers.
// R15: Transition on selected digital pin raises an event.
// R16: Events work on skipped and crossbar pins, never on analog pins; port match here still compares analog pins as 0.
// R17: Ext interrupts select P0.0 to P0.7; port match covers P0.0 to P1.7.
// R18: Input mode bit 1 selects digital, 0 analog.
// R19: After reset all pins are digital.
//
// Chosen here: the register addresses and the Avalon-MM interface to the registers.
`include "ppc_map.vh"
module ppc_port (
   input  wire        clock,
   input  wire        rstn,
   input  wire [3:0]  avs_address,
   input  wire        avs_read,
   input  wire        avs_write,
   input  wire [31:0] avs_writedata,
   output reg  [31:0] avs_readdata,
   output wire        avs_waitrequest,
   input  wire [20:0] pad_i,
   output wire [20:0] pad_o,
   output wire [20:0] pad_oe_n,
   output wire [20:0] pullup_en,
   input  wire        uart_tx,
   output wire        uart_rx,
   output wire        uart_active,
   input  wire [20:0] periph_out,
   input  wire [20:0] periph_claim,
   output wire [20:0] periph_in,
   output wire [20:0] analog_pin,
   output wire        irq
);
   // ==========================================
   // Register state
   reg  [20:0] in_mode_q;
   reg  [20:0] out_mode_q;
   reg  [20:0] skip_q;
   reg  [20:0] out_val_q;
   reg         xbar_en_q;
   reg         wpud_q;
   reg         uart_en_q;
   reg  [7:0]  ext_sel_q;
   reg  [7:0]  mask0_q;
   reg  [7:0]  match0_q;
   reg  [7:0]  mask1_q;
   reg  [7:0]  match1_q;
   reg  [2:0]  stat_q;
   reg  [2:0]  ien_q;
   reg         ack_q;
   reg  [20:0] sync1_q;
   reg  [20:0] sync2_q;
   reg  [20:0] rd_prev_q;
   reg         match_prev_q;
   wire [20:0] rd_val;
   wire [20:0] out_final;
   wire [20:0] drv_pp;
   wire [20:0] routed;
   wire        access;
   wire [7:0]  wb0;

   assign access          = avs_read | avs_write;
   assign avs_waitrequest = access & ~ack_q;
   assign wb0             = avs_writedata[7:0];

   // Two-flop synchroniser for the pads, reset to the pulled-up idle level
   always @(posedge clock or negedge rstn) begin
      if (!rstn) begin
         sync1_q <= `PPC_RST_PAD;
         sync2_q <= `PPC_RST_PAD;
      end else begin
         sync1_q <= pad_i;
         sync2_q <= sync1_q;
      end
   end

   // ==========================================
   // Crossbar routing of peripheral outputs
   // UART is fixed on P0.4 (tx) and P0.5 (rx); other claims need unskipped pins below P2.4
   assign uart_active = xbar_en_q & uart_en_q;
   genvar gi;
   generate
      for (gi = 0; gi < `PPC_NPIN; gi = gi + 1) begin : g_pin
         wire is_uart = uart_active && (gi == 4 || gi == 5);                  // R12
         wire can_xbar = (gi < 20) && !skip_q[gi] && !is_uart;               // R10 R13 R14
         assign routed[gi]    = xbar_en_q & can_xbar & periph_claim[gi];     // R13
         assign out_final[gi] = (gi == 4 && uart_active) ? uart_tx :
                                routed[gi] ? periph_out[gi] : out_val_q[gi];
         assign drv_pp[gi]    = (gi == 5 && uart_active) ? 1'b0 : out_mode_q[gi];
         assign periph_in[gi] = routed[gi] & rd_val[gi];
         assign analog_pin[gi] = ~in_mode_q[gi];                              // R11 R18
         ppc_pin_cell u_cell (
            .in_digital (in_mode_q[gi]),
            .push_pull  (drv_pp[gi]),
            .out_val    ((gi == 5 && uart_active) ? 1'b1 : out_final[gi]),
            .drv_allow  (xbar_en_q),                                          // R2
            .pu_disable (wpud_q),                                             // R8
            .pad_sync   (sync2_q[gi]),
            .pad_o      (pad_o[gi]),
            .pad_oe_n   (pad_oe_n[gi]),
            .pullup_en  (pullup_en[gi]),
            .pin_read   (rd_val[gi])
         );
      end
   endgenerate
   assign uart_rx = rd_val[5];                                                // R12

   // ==========================================
   // Event triggers: ext int 0/1 on port 0, port match on ports 0 and 1
   // Ext ints are gated off on analog pins; port match sees analog pins as 0 and can trigger
   wire [2:0] ev_pin_sel0 = ext_sel_q[2:0];
   wire [2:0] ev_pin_sel1 = ext_sel_q[6:4];
   wire       ev0_lvl = rd_val[ev_pin_sel0] ^ ext_sel_q[3];                  // R17
   wire       ev1_lvl = rd_val[ev_pin_sel1] ^ ext_sel_q[7];                  // R17
   wire       ev0_prev = rd_prev_q[ev_pin_sel0] ^ ext_sel_q[3];
   wire       ev1_prev = rd_prev_q[ev_pin_sel1] ^ ext_sel_q[7];
   wire       match_now = (((rd_val[7:0] ^ match0_q) & mask0_q) != 8'h00) ||
                          (((rd_val[15:8] ^ match1_q) & mask1_q) != 8'h00); // R17
   wire [2:0] ev_set;
   assign ev_set[0] = ev0_lvl & ~ev0_prev & in_mode_q[ev_pin_sel0];          // R15 R16
   assign ev_set[1] = ev1_lvl & ~ev1_prev & in_mode_q[ev_pin_sel1];          // R15 R16
   assign ev_set[2] = match_now & ~match_prev_q;                             // R15 R16
   assign irq = |(stat_q & ien_q);

   always @(posedge clock or negedge rstn) begin
      if (!rstn) begin
         rd_prev_q    <= `PPC_RST_PAD;                                         // No false edge after reset
         match_prev_q <= 1'b0;
      end else begin
         rd_prev_q    <= rd_val;
         match_prev_q <= match_now;
      end
   end

   // ==========================================
   // Register writes and sticky status
   always @(posedge clock or negedge rstn) begin
      if (!rstn) begin
         in_mode_q  <= `PPC_RST_IN_MODE;                                      // R1 R19
         out_mode_q <= `PPC_RST_ZERO;                                         // R1
         skip_q     <= `PPC_RST_ZERO;
         out_val_q  <= `PPC_RST_OUT;
         xbar_en_q  <= 1'b0;                                                  // R1 R2
         wpud_q     <= 1'b0;                                                  // R1
         uart_en_q  <= 1'b0;
         ext_sel_q  <= 8'h00;
         mask0_q    <= 8'h00;
         match0_q   <= 8'h00;
         mask1_q    <= 8'h00;
         match1_q   <= 8'h00;
         stat_q     <= 3'h0;
         ien_q      <= 3'h0;
         ack_q      <= 1'b0;
      end else begin
         ack_q <= access & ~ack_q;
         // Set wins over write-one-to-clear
         if (avs_write && ack_q && avs_address == `PPC_OFS_IRQ)
            stat_q <= (stat_q & ~avs_writedata[2:0]) | ev_set;
         else
            stat_q <= stat_q | ev_set;
         if (avs_write && ack_q) begin
            case (avs_address)
               `PPC_OFS_IN_MODE0:  in_mode_q[7:0]   <= wb0;                   // R18
               `PPC_OFS_IN_MODE1:  in_mode_q[15:8]  <= wb0;
               `PPC_OFS_IN_MODE2:  in_mode_q[20:16] <= avs_writedata[4:0];
               `PPC_OFS_OUT_MODE0: out_mode_q[7:0]   <= wb0;
               `PPC_OFS_OUT_MODE1: out_mode_q[15:8]  <= wb0;
               `PPC_OFS_OUT_MODE2: out_mode_q[20:16] <= avs_writedata[4:0];
               `PPC_OFS_SKIP0:     skip_q[7:0]   <= wb0;                      // R10
               `PPC_OFS_SKIP1:     skip_q[15:8]  <= wb0;
               `PPC_OFS_SKIP2:     skip_q[20:16] <= avs_writedata[4:0];
               `PPC_OFS_OUT0:      out_val_q[7:0]   <= wb0;
               `PPC_OFS_OUT1:      out_val_q[15:8]  <= wb0;
               `PPC_OFS_OUT2:      out_val_q[20:16] <= avs_writedata[4:0];
               `PPC_OFS_CTRL: begin
                  xbar_en_q <= avs_writedata[`PPC_CTRL_XBAR_BIT];
                  wpud_q    <= avs_writedata[`PPC_CTRL_WPUD_BIT];
                  uart_en_q <= avs_writedata[2];
                  ext_sel_q <= avs_writedata[15:8];
               end
               `PPC_OFS_MATCH: begin
                  mask0_q  <= avs_writedata[7:0];
                  match0_q <= avs_writedata[15:8];
                  mask1_q  <= avs_writedata[23:16];
                  match1_q <= avs_writedata[31:24];
               end
               `PPC_OFS_IRQ: ien_q <= avs_writedata[10:8];
               default: ;
            endcase
         end
      end
   end

   // ==========================================
   // Read data, registered on the answer cycle
   always @(posedge clock or negedge rstn) begin
      if (!rstn) begin
         avs_readdata <= 32'h00000000;
      end else if (avs_read && !ack_q) begin
         case (avs_address)
            `PPC_OFS_IN_MODE0:  avs_readdata <= {24'h000000, in_mode_q[7:0]};
            `PPC_OFS_IN_MODE1:  avs_readdata <= {24'h000000, in_mode_q[15:8]};
            `PPC_OFS_IN_MODE2:  avs_readdata <= {27'h0, in_mode_q[20:16]};
            `PPC_OFS_OUT_MODE0: avs_readdata <= {24'h000000, out_mode_q[7:0]};
            `PPC_OFS_OUT_MODE1: avs_readdata <= {24'h000000, out_mode_q[15:8]};
            `PPC_OFS_OUT_MODE2: avs_readdata <= {27'h0, out_mode_q[20:16]};
            `PPC_OFS_SKIP0:     avs_readdata <= {24'h000000, skip_q[7:0]};
            `PPC_OFS_SKIP1:     avs_readdata <= {24'h000000, skip_q[15:8]};
            `PPC_OFS_SKIP2:     avs_readdata <= {27'h0, skip_q[20:16]};
            `PPC_OFS_OUT0:      avs_readdata <= {24'h000000, out_val_q[7:0]};
            `PPC_OFS_OUT1:      avs_readdata <= {24'h000000, out_val_q[15:8]};
            `PPC_OFS_OUT2:      avs_readdata <= {27'h0, out_val_q[20:16]};
            `PPC_OFS_PIN_READ:  avs_readdata <= {11'h0, rd_val};              // R4 R9
            `PPC_OFS_CTRL:      avs_readdata <= {16'h0000, ext_sel_q, 5'h00, uart_en_q, wpud_q, xbar_en_q};
            `PPC_OFS_MATCH:     avs_readdata <= {match1_q, mask1_q, match0_q, mask0_q};
            `PPC_OFS_IRQ:       avs_readdata <= {21'h0, ien_q, 5'h00, stat_q};
            default:            avs_readdata <= 32'h00000000;
         endcase
      end
   end
endmodule

// ==== tb/ppc_board.sv ====
// ==========================================
// Board side of the pads
module ppc_board (
   input  logic        clock,
   input  logic [20:0] pad_o,
   input  logic [20:0] pad_oe_n,
   input  logic [20:0] pullup_en,
   input  logic [20:0] ext_en,
   input  logic [20:0] ext_val,
   output logic [20:0] pad_i
);
   timeunit 1ns;
   timeprecision 100ps;
   logic [20:0] flt_q = 21'h0;
   // Floating pads toggle so no stale level survives
   always @(posedge clock) flt_q <= ~flt_q;
   // Pad level: cell drive, board drive, weak pull-up, else floating
   always_comb
      for (int i = 0; i < 21; i++)
         pad_i[i] = !pad_oe_n[i] ? pad_o[i] : ext_en[i] ? ext_val[i] : pullup_en[i] ? 1'b1 : flt_q[i];
endmodule

// ==== tb/ppc_port_asserts.sv ====
// ==========================================
// Port cell checker
module ppc_port_asserts (
   input logic        clock,
   input logic        rstn,
   input logic [3:0]  avs_address,
   input logic        avs_read,
   input logic        avs_write,
   input logic [31:0] avs_writedata,
   input logic        avs_waitrequest,
   input logic [20:0] pad_o,
   input logic [20:0] pad_oe_n,
   input logic [20:0] pullup_en,
   input logic [20:0] analog_pin,
   input logic        irq
);
   timeunit 1ns;
   timeprecision 100ps;
   logic xb_q;
   logic wpud_q;
   wire  wr_ok = avs_write && !avs_waitrequest;
   default clocking @(posedge clock); endclocking
   default disable iff (!rstn);
   // Shadow of crossbar enable and pull-up disable
   always @(posedge clock or negedge rstn)
      if (!rstn) begin
         xb_q   <= 1'b0;
         wpud_q <= 1'b0;
      end else if (wr_ok && avs_address == 4'hD) begin
         xb_q   <= avs_writedata[0];
         wpud_q <= avs_writedata[1];
      end
   // ==========================================
   // Pin cell, interrupt mask and bus wait relations
   property p_rst_idle; $rose(rstn) |-> &pad_oe_n && &pullup_en && analog_pin == 21'h0; endproperty
   a_rst_idle: assert property (p_rst_idle) else $error("pins not idle after reset");
   property p_xbar_off; !xb_q |-> &pad_oe_n; endproperty
   a_xbar_off: assert property (p_xbar_off) else $error("driver on with crossbar off");
   property p_analog; |analog_pin |-> (analog_pin & (pullup_en | ~pad_oe_n)) == 21'h0; endproperty
   a_analog: assert property (p_analog) else $error("analog pin not isolated");
   property p_pu_low; |(~pad_oe_n & ~pad_o) |-> (~pad_oe_n & ~pad_o & pullup_en) == 21'h0; endproperty
   a_pu_low: assert property (p_pu_low) else $error("pull-up on while driving low");
   property p_pu_float; !wpud_q |-> (pad_oe_n & ~analog_pin & ~pullup_en) == 21'h0; endproperty
   a_pu_float: assert property (p_pu_float) else $error("undriven pin lacks pull-up");
   property p_pu_off; wpud_q |-> pullup_en == 21'h0; endproperty
   a_pu_off: assert property (p_pu_off) else $error("pull-up on while disabled");
   property p_mode_wr; wr_ok && avs_address == 4'h0 |=> analog_pin[7:0] == ~$past(avs_writedata[7:0]); endproperty
   a_mode_wr: assert property (p_mode_wr) else $error("input mode not applied");
   property p_irq_mask; wr_ok && avs_address == 4'hF && avs_writedata[10:8] == 3'h0 |=> !irq; endproperty
   a_irq_mask: assert property (p_irq_mask) else $error("masked interrupt still high");
   property p_wait; $rose(avs_read || avs_write) |-> avs_waitrequest ##1 !avs_waitrequest; endproperty
   a_wait: assert property (p_wait) else $error("access not answered after one wait");
   // Main scenarios reached
   c_xbar: cover property (wr_ok && avs_address == 4'hD && avs_writedata[0]);
   c_analog: cover property (|analog_pin);
   c_irq: cover property ($rose(irq));
endmodule
bind ppc_port ppc_port_asserts u_chk (.clock(clock), .rstn(rstn), .avs_address(avs_address),
   .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata), .irq(irq),
   .avs_waitrequest(avs_waitrequest), .pad_o(pad_o), .pad_oe_n(pad_oe_n), .pullup_en(pullup_en),
   .analog_pin(analog_pin));

// ==== tb/ppc_port_bench.sv ====
module ppc_port_bench;
   timeunit 1ns;
   timeprecision 100ps;
   logic        clock = 1'b0, rstn = 1'b0, rd = 1'b0, wr = 1'b0, utx = 1'b0;
   logic [3:0]  adr = 4'h0;
   logic [31:0] wdat = 32'h0, rdat;
   logic [20:0] pout = 21'h0, pclm = 21'h0, xen = 21'h0, xval = 21'h0, pin, pdo, oen, pue, prt, ana;
   logic        wreq, urx, uact, irq;
   logic [65:0] q[$];
   int          n_fail = 0, check_count = 0;
   ppc_port DUT (.clock(clock), .rstn(rstn), .avs_address(adr), .avs_read(rd), .avs_write(wr),
      .avs_writedata(wdat), .avs_readdata(rdat), .avs_waitrequest(wreq), .pad_i(pin), .pad_o(pdo),
      .pad_oe_n(oen), .pullup_en(pue), .uart_tx(utx), .uart_rx(urx), .uart_active(uact),
      .periph_out(pout), .periph_claim(pclm), .periph_in(prt), .analog_pin(ana), .irq(irq));
   ppc_board u_brd (.clock(clock), .pad_o(pdo), .pad_oe_n(oen), .pullup_en(pue), .ext_en(xen),
      .ext_val(xval), .pad_i(pin));
   // ==========================================
   // Clock and watchdog
   initial begin
      forever #12.5 clock = ~clock;
   end
   initial begin
      #100000;
      n_fail++;
      close_out();
   end
   // ==========================================
   // Bus access, held until waitrequest is seen low
   task automatic acc(input logic w, input logic [3:0] a, input logic [31:0] d);
      int n;
      n = 0;
      @(posedge clock);
      wr <= w;
      rd <= !w;
      adr <= a;
      wdat <= d;
      do begin
         @(posedge clock);
         n++;
      end while (wreq !== 1'b0 && n < 40);
      if (n >= 40) begin
         n_fail++;
         $display("unexpected %0t bus access not answered", $time);
      end
      rd <= 1'b0;
      wr <= 1'b0;
   endtask
   // Let pads settle, note the expectation, then read
   task automatic rd_chk(input logic [3:0] a, input logic [32:0] m, input logic [32:0] e);
      repeat (4) @(posedge clock);
      q.push_back({m, e});
      acc(1'b0, a, 32'h0);
   endtask
   // Low then high pulse from the board on one pin
   task automatic pulse(input int k);
      xval[k] <= 1'b0;
      repeat (4) @(posedge clock);
      xval[k] <= 1'b1;
   endtask
   task automatic close_out;
      $display("checks %0d mismatches %0d", check_count, n_fail);
      if (n_fail == 0 && check_count > 0)
         $display("*** PASS ***");
      else
         $display("*** FAIL ***");
      $finish;
   endtask
   // Compare each completed read and irq with the oldest note
   always @(posedge clock)
      if (rd && wreq === 1'b0) begin
         check_count++;
         if ((({irq, rdat} ^ q[0][32:0]) & q[0][65:33]) !== 33'h0) begin
            n_fail++;
            $display("unexpected %0t at %h got %h/%b", $time, adr, rdat, irq);
         end
         void'(q.pop_front());
      end
   // ==========================================
   // Test sequence
   initial begin
      logic [7:0] r, v, mm;
      r = $urandom(32'hCC60);
      r = $urandom;
      v = $urandom;
      mm = $urandom;
      utx <= 1'($urandom);
      pout <= 21'($urandom);
      repeat (5) @(posedge clock);
      rstn <= 1'b1;
      for (int a = 0; a < 12; a++) begin
         logic [32:0] m;
         m = (a % 3 == 2) ? 33'h1F : 33'hFF;
         rd_chk(4'(a), m, (a < 3 || a > 8) ? m : 33'h0);
      end
      rd_chk(4'hC, 33'h1001FFFFF, 33'h1FFFFF);
      acc(1'b1, 4'h3, 32'hFF);
      acc(1'b1, 4'h9, {24'h0, r});
      rd_chk(4'hC, 33'hFF, 33'hFF);
      acc(1'b1, 4'hD, 32'h1);
      rd_chk(4'hC, 33'hFF, {25'h0, r});
      acc(1'b1, 4'h3, 32'h0);
      rd_chk(4'hC, 33'hFF, {25'h0, r});
      acc(1'b1, 4'hD, 32'h3);
      rd_chk(4'hC, {25'h0, ~r}, 33'h0);
      xen <= 21'h00FF00;
      xval <= {5'h0, v, 8'hFF};
      acc(1'b1, 4'h1, {24'h0, mm});
      rd_chk(4'hC, 33'hFF00, {17'h0, v & mm, 8'h0});
      acc(1'b1, 4'h9, 32'hFF);
      xen <= 21'h00FFFF;
      for (int k = 0; k < 8; k++) begin
         acc(1'b1, 4'hD, 32'h1 | (k << 8) | (k << 12));
         acc(1'b1, 4'hF, 32'h307);
         pulse(k);
         rd_chk(4'hF, 33'h100000707, 33'h100000303);
      end
      acc(1'b1, 4'hF, 32'h7);
      pulse(7);
      rd_chk(4'hF, 33'h100000707, 33'h3);
      acc(1'b1, 4'h0, 32'h7F);
      acc(1'b1, 4'hF, 32'h307);
      pulse(7);
      rd_chk(4'hF, 33'h100000707, 33'h300);
      acc(1'b1, 4'h0, 32'hFF);
      acc(1'b1, 4'hE, 32'h8080);
      acc(1'b1, 4'hF, 32'h407);
      xval[7] <= 1'b0;
      rd_chk(4'hF, 33'h100000707, 33'h100000404);
      // Crossbar claims: UART fixed on P0.4/P0.5, skipped P2.0 and P2.4 outside the crossbar stay GPIO
      xen <= 21'h000020;
      xval <= {15'h0, ~utx, 5'h00};
      pclm <= 21'h1F0030;
      acc(1'b1, 4'hD, 32'h5);
      acc(1'b1, 4'h3, 32'h10);
      acc(1'b1, 4'h5, 32'h1F);
      acc(1'b1, 4'h8, 32'h1);
      acc(1'b1, 4'hB, 32'h0);
      rd_chk(4'hC, 33'h1F0030, {12'h000, 1'b0, pout[19:17], 1'b0, 10'h000, ~utx, utx, 4'h0});
      @(posedge clock);
      check_count++;
      if (prt !== {1'b0, pout[19:17], 17'h00000} || urx !== ~utx || uact !== 1'b1) begin
         n_fail++;
         $display("unexpected %0t crossbar outputs %h %b %b", $time, prt, urx, uact);
      end
      if (q.size() != 0) begin
         n_fail++;
         $display("unexpected %0t reads left unanswered", $time);
      end
      close_out();
   end
endmodule
